/* File: hdl/bbac_top.sv */
// Boot-on-select settings and bank address register with its serial command front end.
`timescale 1ns/1ps
module bbac_top
    import bbac_pkg::*;
#(
    parameter bit DENSITY_256 = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sclk,
    input wire logic ce_n,
    input wire logic si,
    output logic so,
    output logic so_oe_n,
    input wire logic quad_io_enable,
    input wire logic [7:0] nv_bank_value,
    input wire logic [31:0] nv_boot_config,
    output logic nv_bank_wr,
    output logic [7:0] nv_bank_wr_data,
    output logic [7:0] bank_value,
    output logic array_cmd_valid,
    output logic [7:0] array_opcode,
    output logic [31:0] array_addr,
    output logic [31:0] boot_read_addr,
    output logic boot_stream_go
);
    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic frame_rst;
    logic [40:0] to_link;
    logic [40:0] link_s;
    logic [7:0] bank_s;
    logic [31:0] cfg_s;
    logic quad_s;
    logic [39:0] pins_s;
    logic tog_s;
    bbac_state_e state, next_state;
    logic [5:0] bit_cnt, next_cnt;
    logic [31:0] shift, next_shift;
    logic [7:0] out_byte, next_out;
    logic [7:0] opcode, next_opcode;
    logic addr_four, next_four;
    logic next_go;
    logic boot_done, next_boot_done;
    logic post;
    logic [2:0] post_kind;
    logic [3:0] delay_eff;
    logic boot_armed;
    logic ev_tog, next_ev_tog;
    logic [2:0] ev_kind, next_ev_kind;
    logic [7:0] ev_opcode, next_ev_opcode;
    logic [31:0] ev_addr, next_ev_addr;
    logic [7:0] ev_data, next_ev_data;
    logic next_so, next_so_oe_n;
    logic [1:0] init_cnt, next_init_cnt;
    logic loaded, next_loaded;
    logic [7:0] bank, next_bank;
    logic [31:0] boot_cfg, next_boot_cfg;
    logic tog_seen;
    logic take;
    logic [7:0] wr_mask;
    logic next_cmd_valid;
    logic [7:0] next_cmd_opcode;
    logic [31:0] next_cmd_addr;
    logic next_nv_wr;
    logic [7:0] next_nv_data;
    logic [31:0] next_boot_addr;

    // ----------------------------------------------------------------
    // Crossings
    // ----------------------------------------------------------------
    // A deselected device drops all frame state at once, so no edge after the frame is needed.
    assign frame_rst = reset | ce_n;
    assign to_link = {quad_io_enable, boot_cfg, bank};
    assign bank_s = link_s[7:0];
    assign cfg_s = link_s[39:8];
    assign quad_s = link_s[40];

    // Register contents change rarely, so a plain level crossing per bit is enough.
    bbac_sync #(.WIDTH(41)) u_to_link (
        .clk(sclk),
        .reset(reset),
        .d(to_link),
        .q(link_s)
    );

    // Storage straps arrive from outside and settle before the load after reset.
    bbac_sync #(.WIDTH(40)) u_pins (
        .clk(clk),
        .reset(reset),
        .d({nv_bank_value, nv_boot_config}),
        .q(pins_s)
    );

    // The event toggle marks a new, already stable, payload from the link side.
    bbac_sync #(.WIDTH(1)) u_event (
        .clk(clk),
        .reset(reset),
        .d(ev_tog),
        .q(tog_s)
    );

    // ----------------------------------------------------------------
    // Link side: frame decoder
    // ----------------------------------------------------------------
    // Zero in the delay field falls back to the dummy count of the active read style.
    assign delay_eff = (cfg_s[BOOT_DELAY_MSB:BOOT_DELAY_LSB] == 4'h0) ?
                       (quad_s ? BOOT_DELAY_QUAD : BOOT_DELAY_SPI) :
                       cfg_s[BOOT_DELAY_MSB:BOOT_DELAY_LSB];
    // Boot runs on the first frame after reset only, and only while enabled.
    assign boot_armed = cfg_s[BOOT_EN_BIT] & ~boot_done;

    // Next frame state from the bit count and the opcode just shifted in.
    always_comb begin
        next_state = state;
        next_cnt = bit_cnt + 6'd1;
        next_shift = {shift[30:0], si};
        next_out = out_byte;
        next_opcode = opcode;
        next_four = addr_four;
        next_go = boot_stream_go;
        next_boot_done = boot_done;
        post = 1'b0;
        post_kind = EV_NONE;
        case (state)
            ST_OPCODE: begin
                if (boot_armed) begin
                    next_state = ST_BOOT;
                    next_go = (next_cnt == {2'b00, delay_eff});
                end else if (bit_cnt == LAST_BYTE_BIT) begin
                    next_cnt = 6'd0;
                    next_opcode = next_shift[7:0];
                    case (next_shift[7:0])
                        READ_BANK_REG_CMD_A, READ_BANK_REG_CMD_B: begin
                            next_state = ST_DATA_OUT;
                            next_out = bank_s;
                        end
                        WRITE_BANK_REG_VOLATILE_CMD_A, WRITE_BANK_REG_VOLATILE_CMD_B,
                        WRITE_BANK_REG_NONVOLATILE_CMD: begin
                            next_state = ST_DATA_IN;
                        end
                        ENTER_WIDE_ADDR_CMD: begin
                            next_state = ST_IGNORE;
                            post = 1'b1;
                            post_kind = EV_ENTER;
                        end
                        EXIT_WIDE_ADDR_CMD: begin
                            next_state = ST_IGNORE;
                            post = 1'b1;
                            post_kind = EV_EXIT;
                        end
                        LEGACY_READ_CMD, SINGLE_FAST_READ_CMD, QUAD_IO_FAST_READ_CMD,
                        PAGE_PROGRAM_CMD, SECTOR_ERASE_CMD, BLOCK_ERASE_CMD: begin
                            next_state = ST_ADDR;
                            next_four = bank_s[BANK_MODE_BIT];
                        end
                        default: begin
                            next_state = ST_IGNORE;
                        end
                    endcase
                end
            end
            ST_ADDR: begin
                // Field length follows the mode seen when the opcode completed.
                if (bit_cnt == (addr_four ? LAST_ADDR4_BIT : LAST_ADDR3_BIT)) begin
                    next_state = ST_IGNORE;
                    post = 1'b1;
                    post_kind = EV_ADDR;
                end
            end
            ST_DATA_IN: begin
                if (bit_cnt == LAST_BYTE_BIT) begin
                    next_state = ST_IGNORE;
                    post = 1'b1;
                    post_kind = (opcode == WRITE_BANK_REG_NONVOLATILE_CMD) ? EV_WRNV : EV_WRV;
                end
            end
            ST_DATA_OUT: begin
                // The register repeats for as long as the host keeps clocking.
                if (bit_cnt == LAST_BYTE_BIT) begin
                    next_cnt = 6'd0;
                    next_out = bank_s;
                end
            end
            ST_BOOT: begin
                // Boot history is marked only from inside a frame, so deselected clocking cannot use it up.
                next_boot_done = 1'b1;
                if (boot_stream_go) begin
                    next_cnt = bit_cnt;
                end else begin
                    next_go = (next_cnt == {2'b00, delay_eff});
                end
            end
            ST_IGNORE: begin
                next_cnt = bit_cnt;
            end
            default: begin
                next_state = ST_IGNORE;
            end
        endcase
    end

    // Frame registers clear whenever the device is deselected.
    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            state <= ST_OPCODE;
            bit_cnt <= 6'd0;
            shift <= 32'h0000_0000;
            out_byte <= 8'h00;
            opcode <= 8'h00;
            addr_four <= 1'b0;
            boot_stream_go <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_cnt;
            shift <= next_shift;
            out_byte <= next_out;
            opcode <= next_opcode;
            addr_four <= next_four;
            boot_stream_go <= next_go;
        end
    end

    // Event payload: the bank bit extends a 3-byte address, a 4-byte address passes untouched.
    always_comb begin
        next_ev_tog = ev_tog;
        next_ev_kind = ev_kind;
        next_ev_opcode = ev_opcode;
        next_ev_addr = ev_addr;
        next_ev_data = ev_data;
        if (post) begin
            next_ev_tog = ~ev_tog;
            next_ev_kind = post_kind;
            next_ev_opcode = opcode;
            next_ev_data = next_shift[7:0];
            if (addr_four) begin
                next_ev_addr = next_shift;
            end else begin
                next_ev_addr = {7'h00, bank_s[BANK_SEG_BIT], next_shift[23:0]};
            end
        end
    end

    // Payload and boot history must outlive the frame, so only reset clears them.
    always_ff @(posedge sclk or posedge reset) begin
        if (reset) begin
            ev_tog <= 1'b0;
            ev_kind <= EV_NONE;
            ev_opcode <= 8'h00;
            ev_addr <= 32'h0000_0000;
            ev_data <= 8'h00;
            boot_done <= 1'b0;
        end else begin
            ev_tog <= next_ev_tog;
            ev_kind <= next_ev_kind;
            ev_opcode <= next_ev_opcode;
            ev_addr <= next_ev_addr;
            ev_data <= next_ev_data;
            boot_done <= next_boot_done;
        end
    end

    // Read data leaves on the falling edge so the host samples it on the rising one.
    always_comb begin
        next_so_oe_n = (state != ST_DATA_OUT);
        next_so = out_byte[3'd7 - bit_cnt[2:0]];
    end

    always_ff @(negedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            so <= 1'b0;
            so_oe_n <= 1'b1;
        end else begin
            so <= next_so;
            so_oe_n <= next_so_oe_n;
        end
    end

    // ----------------------------------------------------------------
    // System side: registers
    // ----------------------------------------------------------------
    assign take = (tog_s != tog_seen) & loaded;
    // Reserved bits never store, and the segment bit is dead on the small part.
    assign wr_mask = {ev_data[BANK_MODE_BIT], 6'h00, DENSITY_256 & ev_data[BANK_SEG_BIT]};

    // Register updates; events that arrive before the load are dropped.
    always_comb begin
        next_init_cnt = init_cnt;
        next_loaded = loaded;
        next_bank = bank;
        next_boot_cfg = boot_cfg;
        next_cmd_valid = 1'b0;
        next_cmd_opcode = array_opcode;
        next_cmd_addr = array_addr;
        next_nv_wr = 1'b0;
        next_nv_data = nv_bank_wr_data;
        next_boot_addr = {boot_cfg[BOOT_ADDR_MSB:BOOT_ADDR_LSB], 5'h00};
        if (!loaded) begin
            if (init_cnt == INIT_SETTLE) begin
                next_loaded = 1'b1;
                next_bank = {pins_s[39], 6'h00, DENSITY_256 & pins_s[32]};
                next_boot_cfg = pins_s[31:0];
            end else begin
                next_init_cnt = init_cnt + 2'd1;
            end
        end else if (take) begin
            case (ev_kind)
                EV_ENTER: next_bank[BANK_MODE_BIT] = 1'b1;
                EV_EXIT: next_bank[BANK_MODE_BIT] = 1'b0;
                EV_WRV: next_bank = wr_mask;
                EV_WRNV: begin
                    next_bank = wr_mask;
                    next_nv_wr = 1'b1;
                    next_nv_data = wr_mask;
                end
                EV_ADDR: begin
                    next_cmd_valid = 1'b1;
                    next_cmd_opcode = ev_opcode;
                    next_cmd_addr = ev_addr;
                end
                default: begin
                end
            endcase
        end
    end

    // Shipped state: 3-byte mode, lower segment, boot disabled.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            init_cnt <= 2'd0;
            loaded <= 1'b0;
            bank <= BANK_RESET;
            boot_cfg <= BOOT_CFG_RESET;
            tog_seen <= 1'b0;
            array_cmd_valid <= 1'b0;
            array_opcode <= 8'h00;
            array_addr <= 32'h0000_0000;
            nv_bank_wr <= 1'b0;
            nv_bank_wr_data <= 8'h00;
            boot_read_addr <= 32'h0000_0000;
        end else begin
            init_cnt <= next_init_cnt;
            loaded <= next_loaded;
            bank <= next_bank;
            boot_cfg <= next_boot_cfg;
            tog_seen <= tog_s;
            array_cmd_valid <= next_cmd_valid;
            array_opcode <= next_cmd_opcode;
            array_addr <= next_cmd_addr;
            nv_bank_wr <= next_nv_wr;
            nv_bank_wr_data <= next_nv_data;
            boot_read_addr <= next_boot_addr;
        end
    end

    assign bank_value = bank;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence seq_enter_taken;
        take && (ev_kind == EV_ENTER);
    endsequence

    sequence seq_exit_taken;
        take && (ev_kind == EV_EXIT);
    endsequence

    sequence seq_boot_spi_start;
        (state == ST_OPCODE) && boot_armed && (cfg_s[BOOT_DELAY_MSB:BOOT_DELAY_LSB] == 4'h0) && !quad_s;
    endsequence

    sequence seq_boot_quad_start;
        (state == ST_OPCODE) && boot_armed && (cfg_s[BOOT_DELAY_MSB:BOOT_DELAY_LSB] == 4'h0) && quad_s;
    endsequence

    AST_ENTER_SETS_MODE: assert property (@(posedge clk) disable iff (reset)
        seq_enter_taken |=> bank[BANK_MODE_BIT] ##1 bank[BANK_MODE_BIT])
        else $error("Enter command did not select 4-byte mode.");

    AST_EXIT_CLEARS_MODE: assert property (@(posedge clk) disable iff (reset)
        seq_exit_taken |=> !bank[BANK_MODE_BIT])
        else $error("Exit command did not return to 3-byte mode.");

    AST_VOLATILE_WRITE: assert property (@(posedge clk) disable iff (reset)
        (take && ev_kind == EV_WRV) |=> (bank == $past(wr_mask)) && !nv_bank_wr)
        else $error("Volatile bank write stored the wrong value.");

    AST_NONVOLATILE_WRITE: assert property (@(posedge clk) disable iff (reset)
        (take && ev_kind == EV_WRNV) |=> nv_bank_wr && (nv_bank_wr_data == bank) ##1 !nv_bank_wr)
        else $error("Non-volatile bank write was not issued once.");

    AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (reset)
        bank[6:1] == 6'h00)
        else $error("Reserved bank bits are not zero.");

    AST_BOOT_ALIGNED: assert property (@(posedge clk) disable iff (reset)
        boot_read_addr[4:0] == 5'h00)
        else $error("Boot start address is not 32-byte aligned.");

    AST_CMD_FORWARD: assert property (@(posedge clk) disable iff (reset)
        (take && ev_kind == EV_ADDR) |=> array_cmd_valid && (array_addr == $past(ev_addr)) ##1 !array_cmd_valid)
        else $error("Address command was not forwarded intact.");

    AST_ADDR3_EXTENDED: assert property (@(posedge sclk) disable iff (reset)
        (post && post_kind == EV_ADDR && !addr_four) |=>
        (ev_addr[31:25] == 7'h00) && (ev_addr[24] == $past(bank_s[BANK_SEG_BIT])))
        else $error("3-byte address lacks the bank segment bit.");

    AST_ADDR4_LENGTH: assert property (@(posedge sclk) disable iff (frame_rst)
        (state == ST_ADDR && addr_four && bit_cnt == LAST_ADDR4_BIT) |=> (ev_tog != $past(ev_tog)))
        else $error("4-byte address field did not close after 32 bits.");

    AST_BOOT_SPI_DELAY: assert property (@(posedge sclk) disable iff (frame_rst)
        seq_boot_spi_start |=> (!boot_stream_go) [*7] ##1 boot_stream_go)
        else $error("Default boot delay without quad is not 8 cycles.");

    AST_BOOT_QUAD_DELAY: assert property (@(posedge sclk) disable iff (frame_rst)
        seq_boot_quad_start |=> (!boot_stream_go) [*5] ##1 boot_stream_go)
        else $error("Default boot delay with quad is not 6 cycles.");

    AST_BOOT_NEEDS_ENABLE: assert property (@(posedge sclk) disable iff (frame_rst)
        $rose(boot_stream_go) |-> cfg_s[BOOT_EN_BIT] && (bit_cnt == {2'b00, delay_eff}))
        else $error("Boot stream started while disabled or at the wrong count.");

endmodule // bbac_top

/* File: shared/bbac_pkg.sv */
// Constants, field layout, opcodes and state type of the boot and bank address configuration block.
package bbac_pkg;

    // ----------------------------------------------------------------
    // Boot-on-select configuration word layout
    // ----------------------------------------------------------------
    localparam int BOOT_ADDR_MSB = 31;
    localparam int BOOT_ADDR_LSB = 5;
    localparam int BOOT_DELAY_MSB = 4;
    localparam int BOOT_DELAY_LSB = 1;
    localparam int BOOT_EN_BIT = 0;
    localparam logic [31:0] BOOT_CFG_RESET = 32'h0000_0000;
    localparam logic [3:0] BOOT_DELAY_SPI = 4'h8;
    localparam logic [3:0] BOOT_DELAY_QUAD = 4'h6;

    // ----------------------------------------------------------------
    // Bank address and mode register layout
    // ----------------------------------------------------------------
    localparam int BANK_SEG_BIT = 0;
    localparam int BANK_MODE_BIT = 7;
    localparam logic [7:0] BANK_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Serial opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] READ_BANK_REG_CMD_A = 8'h16;
    localparam logic [7:0] READ_BANK_REG_CMD_B = 8'hc8;
    localparam logic [7:0] WRITE_BANK_REG_VOLATILE_CMD_A = 8'h17;
    localparam logic [7:0] WRITE_BANK_REG_VOLATILE_CMD_B = 8'hc5;
    localparam logic [7:0] WRITE_BANK_REG_NONVOLATILE_CMD = 8'h18;
    localparam logic [7:0] ENTER_WIDE_ADDR_CMD = 8'hb7;
    localparam logic [7:0] EXIT_WIDE_ADDR_CMD = 8'h29;
    // Legacy commands that carry an address field.
    localparam logic [7:0] LEGACY_READ_CMD = 8'h03;
    localparam logic [7:0] SINGLE_FAST_READ_CMD = 8'h0b;
    localparam logic [7:0] QUAD_IO_FAST_READ_CMD = 8'heb;
    localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
    localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
    localparam logic [7:0] BLOCK_ERASE_CMD = 8'hd8;

    // ----------------------------------------------------------------
    // Bit counts and event kinds
    // ----------------------------------------------------------------
    localparam logic [5:0] LAST_BYTE_BIT = 6'd7;
    localparam logic [5:0] LAST_ADDR3_BIT = 6'd23;
    localparam logic [5:0] LAST_ADDR4_BIT = 6'd31;
    localparam logic [1:0] INIT_SETTLE = 2'd2;
    localparam logic [2:0] EV_NONE = 3'd0;
    localparam logic [2:0] EV_ENTER = 3'd1;
    localparam logic [2:0] EV_EXIT = 3'd2;
    localparam logic [2:0] EV_WRV = 3'd3;
    localparam logic [2:0] EV_WRNV = 3'd4;
    localparam logic [2:0] EV_ADDR = 3'd5;

    // Link state, Gray coded along opcode, address, data and boot.
    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000,
        ST_ADDR = 3'b001,
        ST_DATA_IN = 3'b011,
        ST_DATA_OUT = 3'b010,
        ST_BOOT = 3'b110,
        ST_IGNORE = 3'b111
    } bbac_state_e;

endpackage

/* File: hdl/bbac_sync.sv */
// Two-flop level synchroniser for quasi-static words.
`timescale 1ns/1ps
module bbac_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // The first stage feeds only the second; words must be stable across several edges.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule // bbac_sync

/* File: tb/bbac_host.sv */
// Serial host model that frames commands towards the configuration block.
`timescale 1ns/1ps
module bbac_host (
    output logic sclk,
    output logic ce_n,
    output logic si,
    input wire logic so
);
    // The clock stands low between frames and select idles high.
    initial begin
        sclk = 1'b0;
        ce_n = 1'b1;
        si = 1'b0;
    end
    // Shift n bits out MSB first; read data is caught on each rising edge.
    // A four-byte address is simply a longer bit count here.
    task automatic frame(input logic [63:0] bits, input int n, input bit hold, output logic [7:0] rd);
        rd = 8'h00;
        ce_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = bits[n-1-i];
            #40 sclk = 1'b1;
            rd = {rd[6:0], so};
            #40 sclk = 1'b0;
        end
        if (!hold) begin
            // A released line shows the inverse of the last bit, never a stale copy.
            si = ~si;
            ce_n = 1'b1;
        end
    endtask
    // Clocking while deselected lets the link side see settled register contents before a frame.
    task automatic idle(input int n);
        for (int i = 0; i < n; i++) begin
            #40 sclk = 1'b1;
            #40 sclk = 1'b0;
        end
    endtask
endmodule // bbac_host

/* File: tb/bbac_top_test.sv */
// Self-checking bench for the boot and bank address configuration block.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module bbac_top_test;
    import bbac_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic quad = 1'b0;
    int cmd_pulses = 0;
    int nv_pulses = 0;
    logic sclk, ce_n, si, so, so_oe_n, nv_bank_wr, array_cmd_valid, boot_stream_go;
    logic [7:0] nv_bank_value = 8'h7f;
    logic [31:0] nv_boot_config = 32'hdead_bee1;
    logic [7:0] nv_bank_wr_data, bank_value, array_opcode, rd;
    logic [31:0] array_addr, boot_read_addr;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    // ------------------------------------------------------------
    // Clock, timeout and instances
    // ------------------------------------------------------------
    always #20 clk = ~clk;
    // A hung handshake must not stall the run forever; strobes are counted to catch lost or doubled pulses.
    always @(posedge clk) begin
        cycles++;
        if (array_cmd_valid === 1'b1) begin
            cmd_pulses++;
        end
        if (nv_bank_wr === 1'b1) begin
            nv_pulses++;
        end
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end
    // A released data line floats to its pull-up level.
    bbac_host bbac_host_inst (.sclk(sclk), .ce_n(ce_n), .si(si), .so(so_oe_n ? 1'b1 : so));
    bbac_top bbac_top_inst (.clk(clk), .reset(reset), .sclk(sclk), .ce_n(ce_n), .si(si), .so(so),
        .so_oe_n(so_oe_n), .quad_io_enable(quad), .nv_bank_value(nv_bank_value),
        .nv_boot_config(nv_boot_config), .nv_bank_wr(nv_bank_wr), .nv_bank_wr_data(nv_bank_wr_data),
        .bank_value(bank_value), .array_cmd_valid(array_cmd_valid), .array_opcode(array_opcode),
        .array_addr(array_addr), .boot_read_addr(boot_read_addr), .boot_stream_go(boot_stream_go));
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Mode changes need several system cycles to reach the system side.
    task automatic settle();
        repeat (10) @(posedge clk);
        #1;
    endtask
    task automatic send(input logic [63:0] bits, input int n);
        bbac_host_inst.frame(bits, n, 1'b0, rd);
        settle();
    endtask
    // Load from storage, reserved bits dropped, boot waits eight cycles.
    task automatic test_reset_boot();
        `CHK(bank_value, 8'h01)
        `CHK(boot_read_addr, 32'hdead_bee0)
        bbac_host_inst.idle(2);
        bbac_host_inst.frame(64'h0, 7, 1'b1, rd);
        `CHK(boot_stream_go, 1'b0)
        bbac_host_inst.frame(64'h0, 1, 1'b1, rd);
        `CHK(boot_stream_go, 1'b1)
        bbac_host_inst.frame(64'h0, 1, 1'b0, rd);
        settle();
    endtask
    // Three-byte address gains the segment bit above A23.
    task automatic test_addr3();
        send({8'h03, 24'h123456}, 32);
        `CHK(array_opcode, 8'h03)
        `CHK(array_addr, 32'h0112_3456)
    endtask
    // Volatile write, readback, and mode entry and exit.
    task automatic test_bank_cmds();
        send({8'h17, 8'hff}, 16);
        `CHK(bank_value, 8'h81)
        bbac_host_inst.frame(64'hc8, 8, 1'b1, rd);
        #1;
        `CHK(so_oe_n, 1'b0)
        bbac_host_inst.frame(64'h0, 8, 1'b0, rd);
        settle();
        `CHK(rd, 8'h81)
        `CHK(so_oe_n, 1'b1)
        send({8'h29}, 8);
        `CHK(bank_value, 8'h01)
        send({8'hb7}, 8);
        `CHK(bank_value, 8'h81)
    endtask
    // Four-byte mode ignores the segment bit and takes the whole field.
    task automatic test_addr4();
        send({8'h0b, 32'hfedc_ba98}, 40);
        `CHK(array_addr, 32'hfedc_ba98)
        send({8'h18, 8'h80}, 16);
        `CHK(nv_bank_wr_data, 8'h80)
        `CHK(bank_value, 8'h80)
        `CHK(cmd_pulses, 2)
        `CHK(nv_pulses, 1)
    endtask
    // A second reset with quad mode on reloads the bank and boots after six cycles.
    task automatic test_quad_boot();
        quad = 1'b1;
        reset = 1'b1;
        repeat (4) @(posedge clk);
        #1 reset = 1'b0;
        settle();
        `CHK(bank_value, 8'h01)
        bbac_host_inst.idle(2);
        bbac_host_inst.frame(64'h0, 5, 1'b1, rd);
        `CHK(boot_stream_go, 1'b0)
        bbac_host_inst.frame(64'h0, 1, 1'b1, rd);
        `CHK(boot_stream_go, 1'b1)
        bbac_host_inst.frame(64'h0, 1, 1'b0, rd);
        settle();
    endtask
    // ------------------------------------------------------------
    // Sequence and verdict
    // ------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1 reset = 1'b0;
        settle();
        test_reset_boot();
        test_addr3();
        test_bank_cmds();
        test_addr4();
        test_quad_boot();
        conclude();
    end
endmodule // bbac_top_test
